// *** common/adcc_params.svh ***
// offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ----------------------------------------------------------------------
// register map: printed offsets, base, and word index on the bus
// ----------------------------------------------------------------------
`define ADCC_BASE_OFFSET 32'h0080_0080
`define ADCC_SIM0_OFFSET 32'h0080_0080
`define ADCC_SIM1_OFFSET 32'h0080_0081
`define ADCC_SCM0_OFFSET 32'h0080_0084
`define ADCC_ADDR_W 3
`define ADCC_SIM0_IDX 3'h0
`define ADCC_SIM1_IDX 3'h1
`define ADCC_SCM0_IDX 3'h4

// ----------------------------------------------------------------------
// single_mode_control fields (D0 is the byte lsb)
// ----------------------------------------------------------------------
`define ADCC_S_HWSRC_BIT 5
`define ADCC_S_TRIG_BIT 4
`define ADCC_S_REQ_BIT 3
`define ADCC_S_DONE_BIT 2
`define ADCC_S_HALT_BIT 1
`define ADCC_S_GO_BIT 0
`define ADCC_SIM0_RESET 8'h04

// ----------------------------------------------------------------------
// single_mode_channel_config fields
// ----------------------------------------------------------------------
`define ADCC_S_FUNC_BIT 7
`define ADCC_S_RATE_BIT 6
`define ADCC_S_CH_MSB 3
`define ADCC_S_CH_LSB 0
`define ADCC_SIM1_RESET 8'h00

// ----------------------------------------------------------------------
// scan_mode_control fields
// ----------------------------------------------------------------------
`define ADCC_C_REPEAT_BIT 6
`define ADCC_C_HWSRC_BIT 5
`define ADCC_C_TRIG_BIT 4
`define ADCC_C_REQ_BIT 3
`define ADCC_C_DONE_BIT 2
`define ADCC_C_HALT_BIT 1
`define ADCC_C_GO_BIT 0
`define ADCC_SCM0_RESET 8'h04

// ----------------------------------------------------------------------
// bus answer timing: cycles of waitrequest before an access completes
// ----------------------------------------------------------------------
`define ADCC_WAIT_CYCLES 1

`endif

// *** common/adcc_pkg.sv ***
// types shared by the converter control block
package adcc_pkg;

    // controller state, one-hot
    typedef enum logic [2:0] {
        ADCC_IDLE   = 3'b001,
        ADCC_SINGLE = 3'b010,
        ADCC_SCAN   = 3'b100
    } adcc_state_t;

    // command handed to the conversion core with each start
    typedef struct packed {
        logic [3:0] channel;
        logic compare;
        logic rate;
    } adcc_cmd_t;

    // completion requests towards the interrupt and dma controllers
    typedef struct packed {
        logic irq;
        logic dma;
    } adcc_req_t;

endpackage

// *** verif/adcc_core_model.sv ***
// behavioural conversion core facing the control block
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control side
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [4:0] dly,
    output logic conv_done
);
    logic [4:0] cnt_q;

    // conversion length is set by the bench, so slow and quick both occur
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_q == 5'h01) && !conv_start && !conv_abort;
            if (conv_start)
                cnt_q <= dly; // a new start drops the old one
            else if (conv_abort)
                cnt_q <= 5'h00; // count cleared, no finish
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
        end
    end
endmodule
`default_nettype wire

// *** verif/adcc_ctrl_props.sv ***
// port checker of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_ctrl_props
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // events and core
    input wire logic evt_bus3,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic conv_store,
    input wire logic conv_done,
    input wire adcc_req_t done_req
);
    // ------------------------------------------------------------
    // one clock domain, so clocking and disable are set once
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_wait_one_cycle: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_hi_bytes_zero: assert property (
        avs_readdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_req_one_kind: assert property (
        !(done_req.irq && done_req.dma))
        else $error("interrupt and dma requested together");
    a_req_with_store: assert property (
        (done_req.irq || done_req.dma) |-> conv_store)
        else $error("completion request without result store");
    a_store_after_done: assert property (
        conv_store |-> $past(conv_done))
        else $error("store without core completion");
    a_abort_cause: assert property (
        conv_abort |-> $past(avs_write && !avs_waitrequest && avs_writedata[1]))
        else $error("abort without stop write");
    a_start_cause: assert property (
        conv_start |-> $past((avs_write && !avs_waitrequest) || evt_bus3
        || conv_done))
        else $error("start without a cause");
    a_abort_alone: assert property (
        conv_abort |-> !conv_start && !conv_store)
        else $error("abort together with start or store");
    a_start_pulse: assert property (
        conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");

    // main scenarios reached
    c_irq: cover property (done_req.irq);
    c_dma: cover property (done_req.dma);
    c_abort: cover property (conv_abort);
endmodule

bind adcc_ctrl adcc_ctrl_props u_props (
    .sys_clk(sys_clk), .nrst(nrst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .evt_bus3(evt_bus3), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_store(conv_store), .conv_done(conv_done), .done_req(done_req)
);
`default_nettype wire

// *** verif/adcc_ctrl_test.sv ***
// self-checking bench of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_ctrl_test import adcc_pkg::*;;
    logic sys_clk = 1'b0, nrst = 1'b0, evt_bus3 = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF, scan_last_ch = 4'h3;
    logic [4:0] dly = 5'h08;
    logic avs_waitrequest, conv_start, conv_abort, conv_store, conv_done, wq_n;
    logic [7:0] rq_n, q, v;
    adcc_cmd_t conv_cmd, cmd_seen;
    adcc_req_t done_req;
    int err_count = 0, checks = 0, n_st = 0, n_so = 0, n_ab = 0, n_ev = 0;
    int s, so, e, k, b;

    always #25 sys_clk = ~sys_clk;
    // sample outputs mid-cycle, where registered values are settled
    always @(negedge sys_clk) begin
        wq_n = avs_waitrequest;
        rq_n = avs_readdata[7:0];
        if (conv_start === 1'b1) begin
            n_st++;
            cmd_seen = conv_cmd;
        end
        if (conv_store === 1'b1) n_so++;
        if (conv_abort === 1'b1) n_ab++;
        if (done_req !== 2'b00) n_ev++;
    end

    adcc_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .evt_bus3(evt_bus3), .scan_last_ch(scan_last_ch), .conv_cmd(conv_cmd),
        .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_store(conv_store), .conv_done(conv_done), .done_req(done_req));
    adcc_core_model u_core (.sys_clk(sys_clk), .nrst(nrst),
        .conv_start(conv_start), .conv_abort(conv_abort), .dly(dly),
        .conv_done(conv_done));

    // expected control byte: rep, hw source, trigger, request, done
    function automatic logic [7:0] e_ctl(input logic r, h, t, rq, d);
        return {1'b0, r, h, t, rq, d, 2'b00};
    endfunction

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        chk_reg(got[7:0], exp[7:0]);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d);
        int i;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (wq_n !== 1'b0 && i < 20);
        q = rq_n;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i >= 20) begin
            err_count++;
            end_sim;
        end
        @(posedge sys_clk);
    endtask
    // bounded wait for a completion request count
    task automatic wait_ev(input int tgt);
        int i;
        for (i = 0; i < 3000 && n_ev < tgt; i++) @(posedge sys_clk);
        if (n_ev < tgt) begin
            err_count++;
            end_sim;
        end
    endtask
    task automatic pulse_evt;
        evt_bus3 <= 1'b1;
        @(posedge sys_clk);
        evt_bus3 <= 1'b0;
        tick(3);
    endtask

    initial begin
        void'($urandom(23512));
        tick(20);
        nrst <= 1'b1;
        tick(4);
        bus(3'h0, 0, 8'h00); chk_reg(q, e_ctl(0, 0, 0, 0, 1));
        bus(3'h1, 0, 8'h00); chk_reg(q, 8'h00);
        bus(3'h4, 0, 8'h00); chk_reg(q, e_ctl(0, 0, 0, 0, 1));
        bus(3'h2, 0, 8'h00); chk_reg(q, 8'h00);
        bus(3'h0, 1, 8'hC0); bus(3'h0, 0, 8'h00);
        chk_reg(q, e_ctl(0, 0, 0, 0, 1));
        $display("test reset done");
        // all function and request modes, random channel and rate
        for (b = 0; b < 4; b++) begin
            v = {b[1], 1'($urandom), 2'b00, 4'($urandom)};
            bus(3'h1, 1, v); bus(3'h1, 0, 8'h00); chk_reg(q, v);
            dly <= 5'(8 + $urandom % 8);
            e = n_ev;
            bus(3'h0, 1, {4'h0, b[0], 3'b001});
            bus(3'h0, 0, 8'h00); chk_reg(q, e_ctl(0, 0, 0, b[0], 0));
            wait_ev(e + 1);
            chk_reg({2'b00, cmd_seen}, {2'b00, v[3:0], v[7], v[6]});
            bus(3'h0, 0, 8'h00); chk_reg(q, e_ctl(0, 0, 0, b[0], 1));
        end
        $display("test single done");
        s = n_st; so = n_so; k = n_ab;
        bus(3'h0, 1, 8'h01); bus(3'h0, 1, 8'h02); tick(20);
        chk_cnt(n_ab, k + 1);
        chk_cnt(n_so, so);
        bus(3'h0, 0, 8'h00); chk_reg(q, e_ctl(0, 0, 0, 0, 1));
        bus(3'h0, 1, 8'h03); tick(20);
        chk_cnt(n_st, s + 1);
        chk_cnt(n_ab, k + 1);
        $display("test stop done");
        bus(3'h1, 1, 8'h00); bus(3'h0, 1, 8'h30); e = n_ev;
        pulse_evt; chk_cnt(n_st, s + 2);
        wait_ev(e + 1);
        bus(3'h0, 1, 8'h31); tick(3); chk_cnt(n_st, s + 2);
        bus(3'h0, 1, 8'h10); pulse_evt; chk_cnt(n_st, s + 2);
        bus(3'h1, 1, 8'h80); bus(3'h0, 1, 8'h30);
        pulse_evt; chk_cnt(n_st, s + 2);
        bus(3'h1, 1, 8'h09); bus(3'h0, 1, 8'h00);
        $display("test trigger done");
        for (b = 0; b < 2; b++) begin
            scan_last_ch <= b ? 4'h7 : 4'h3;
            s = n_st; so = n_so; e = n_ev;
            bus(3'h4, 1, {1'b0, b[0], 6'h01});
            bus(3'h4, 0, 8'h00); chk_reg(q, e_ctl(b[0], 0, 0, 0, 0));
            wait_ev(e + 1 + b);
            chk_cnt(n_so - so, (b + 1) * (b ? 8 : 4));
            if (b == 1) begin
                e = n_ev;
                bus(3'h0, 1, 8'h01); tick(3); so = n_so;
                chk_reg({4'h0, cmd_seen.channel}, 8'h09);
                bus(3'h0, 1, 8'h02); chk_cnt(n_so, so);
                wait_ev(e + 1);
                bus(3'h4, 1, 8'h42); tick(2);
                chk_cnt(n_ab, k + 2);
            end
            bus(3'h4, 0, 8'h00); chk_reg(q, e_ctl(b[0], 0, 0, 0, 1));
        end
        $display("test scan done");
        end_sim;
    end
endmodule
`default_nettype wire

// *** verilog/adcc_ctrl.sv ***
// single and scan mode control for one successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
`include "adcc_params.svh"

// Operation
// - single trigger bit picks software or event start
// - single event source bit selects event bus three
// - comparator mode ignores event, software start only
// - single completion requests interrupt or dma
// - single done flag: one idle, zero busy
// - forced single stop also sets done flag
// - single stop halts running single only
// - single stop keeps partial value, no store
// - stop beats start in same write
// - stop inside inserted single resumes scan
// - single start bit works under software trigger
// - single start while single runs restarts it
// - single start in scan inserts, then resumes
// - function bit: conversion or comparator
// - rate bit: normal or double speed
// - channel field selects input, reads back
// - scan cycle completion requests interrupt or dma
// - scan done flag: zero busy, one done
// - scan stop bit stops scan, zero ignored
// - scan stop aborts channel, no store
// - continuous scan wraps to first channel
// - scan start queues after single, restarts scan
module adcc_ctrl
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // avalon-mm register slave
    input wire logic [`ADCC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // timer output event bus, line three, one-cycle pulse
    input wire logic evt_bus3,
    // last scan channel, from the scan loop selection outside
    input wire logic [3:0] scan_last_ch,
    // conversion core
    output adcc_cmd_t conv_cmd,
    output logic conv_start,
    output logic conv_abort,
    output logic conv_store,
    input wire logic conv_done,
    // completion requests
    output adcc_req_t done_req
);

    // ------------------------------------------------------------------
    // reset release through two flip-flops
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    // async assert, synchronous release so no flop leaves reset mid-edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // ------------------------------------------------------------------
    // bus slave handshake
    // ------------------------------------------------------------------
    logic wait_q;
    logic [31:0] rdata_q;
    logic req;
    logic wr_acc;
    logic [7:0] wdat;

    assign req = avs_read | avs_write;
    // access completes at the edge where waitrequest is seen low
    assign wr_acc = avs_write & !wait_q & avs_byteenable[0];
    assign wdat = avs_writedata[7:0];

    // one wait cycle gives time to register read data from flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // software-held control bits
    // ------------------------------------------------------------------
    logic s_hwsrc_q;
    logic s_trig_q;
    logic s_req_q;
    logic s_func_q;
    logic s_rate_q;
    logic [3:0] s_ch_q;
    logic c_repeat_q;
    logic c_hwsrc_q;
    logic c_trig_q;
    logic c_req_q;

    // true when a given register is written this cycle
    function automatic logic hit(input logic [`ADCC_ADDR_W-1:0] idx,
                                 input logic [`ADCC_ADDR_W-1:0] a,
                                 input logic w);
        hit = w && (a == idx);
    endfunction

    // unassigned bits are never stored, so they read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_hwsrc_q <= 1'b0;
            s_trig_q <= 1'b0;
            s_req_q <= 1'b0;
            s_func_q <= 1'b0;
            s_rate_q <= 1'b0;
            s_ch_q <= 4'h0;
            c_repeat_q <= 1'b0;
            c_hwsrc_q <= 1'b0;
            c_trig_q <= 1'b0;
            c_req_q <= 1'b0;
        end else begin
            if (hit(`ADCC_SIM0_IDX, avs_address, wr_acc)) begin
                s_hwsrc_q <= wdat[`ADCC_S_HWSRC_BIT];
                s_trig_q <= wdat[`ADCC_S_TRIG_BIT];
                s_req_q <= wdat[`ADCC_S_REQ_BIT];
            end
            if (hit(`ADCC_SIM1_IDX, avs_address, wr_acc)) begin
                s_func_q <= wdat[`ADCC_S_FUNC_BIT];
                s_rate_q <= wdat[`ADCC_S_RATE_BIT];
                s_ch_q <= wdat[`ADCC_S_CH_MSB:`ADCC_S_CH_LSB];
            end
            if (hit(`ADCC_SCM0_IDX, avs_address, wr_acc)) begin
                c_repeat_q <= wdat[`ADCC_C_REPEAT_BIT];
                c_hwsrc_q <= wdat[`ADCC_C_HWSRC_BIT];
                c_trig_q <= wdat[`ADCC_C_TRIG_BIT];
                c_req_q <= wdat[`ADCC_C_REQ_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // start and stop decode
    // ------------------------------------------------------------------
    logic sim0_wr;
    logic scm0_wr;
    logic s_halt;
    logic s_go;
    logic c_halt;
    logic c_go;

    assign sim0_wr = hit(`ADCC_SIM0_IDX, avs_address, wr_acc);
    assign scm0_wr = hit(`ADCC_SCM0_IDX, avs_address, wr_acc);

    // go and halt exist only in the write cycle
    assign s_halt = sim0_wr & wdat[`ADCC_S_HALT_BIT];
    assign c_halt = scm0_wr & wdat[`ADCC_C_HALT_BIT];

    // a stop in the same write masks the start
    // comparator mode takes only the start bit, never the event;
    // the event needs hardware trigger and source bit set
    assign s_go = !s_halt &&
        ((sim0_wr && wdat[`ADCC_S_GO_BIT] &&
          (!s_trig_q || s_func_q)) ||
         (evt_bus3 && s_trig_q && s_hwsrc_q && !s_func_q));
    assign c_go = !c_halt &&
        ((scm0_wr && wdat[`ADCC_C_GO_BIT] && !c_trig_q) ||
         (evt_bus3 && c_trig_q && c_hwsrc_q));

    // ------------------------------------------------------------------
    // sequencing state
    // ------------------------------------------------------------------
    adcc_state_t state_q;
    logic scan_held_q; // scan suspended under an inserted single
    logic scan_queued_q; // scan waits for the running single
    logic [3:0] scan_ch_q;
    logic s_done_q;
    logic c_done_q;
    logic cyc_end;

    // a scan conversion that finishes the selected loop
    assign cyc_end = (state_q == ADCC_SCAN) && conv_done &&
        (scan_ch_q == scan_last_ch);

    // main sequencer; core restarts on every new start pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ADCC_IDLE;
            scan_held_q <= 1'b0;
            scan_queued_q <= 1'b0;
            scan_ch_q <= 4'h0;
        end else begin
            unique case (state_q)
                ADCC_IDLE: begin
                    if (s_go) begin
                        state_q <= ADCC_SINGLE;
                        scan_queued_q <= c_go;
                    end else if (c_go) begin
                        state_q <= ADCC_SCAN;
                        scan_ch_q <= 4'h0;
                    end
                end
                ADCC_SINGLE: begin
                    if (c_halt) begin
                        // scan stop leaves the single running
                        scan_held_q <= 1'b0;
                        scan_queued_q <= 1'b0;
                    end else if (c_go) begin
                        scan_queued_q <= 1'b1;
                        scan_held_q <= 1'b0;
                        scan_ch_q <= 4'h0;
                    end
                    if (s_halt || (conv_done && !s_go)) begin
                        // back to scan, held or queued
                        if ((scan_held_q || scan_queued_q || c_go) &&
                            !c_halt) begin
                            state_q <= ADCC_SCAN;
                            if (scan_queued_q || c_go) begin
                                scan_ch_q <= 4'h0;
                            end
                        end else begin
                            state_q <= ADCC_IDLE;
                        end
                        scan_held_q <= 1'b0;
                        scan_queued_q <= 1'b0;
                    end
                end
                ADCC_SCAN: begin
                    if (c_halt) begin
                        state_q <= ADCC_IDLE;
                    end else if (s_go) begin
                        // channel cancelled, resumed later
                        state_q <= ADCC_SINGLE;
                        scan_held_q <= 1'b1;
                        if (c_go) begin
                            scan_ch_q <= 4'h0;
                        end
                    end else if (c_go) begin
                        scan_ch_q <= 4'h0;
                    end else if (conv_done) begin
                        if (scan_ch_q != scan_last_ch) begin
                            scan_ch_q <= scan_ch_q + 4'h1;
                        end else if (c_repeat_q) begin
                            scan_ch_q <= 4'h0;
                        end else begin
                            state_q <= ADCC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // completion flags
    // ------------------------------------------------------------------
    // single flag: cleared by a start, set at the end or the stop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_done_q <= 1'b1;
        end else if (state_q == ADCC_SINGLE && s_halt) begin
            s_done_q <= 1'b1;
        end else if (s_go) begin
            s_done_q <= 1'b0;
        end else if (state_q == ADCC_SINGLE && conv_done) begin
            s_done_q <= 1'b1;
        end
    end

    // scan flag: low from start to stop, or to loop end if not continuous
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_done_q <= 1'b1;
        end else if (c_halt && (state_q == ADCC_SCAN ||
                                scan_held_q || scan_queued_q)) begin
            c_done_q <= 1'b1;
        end else if (c_go) begin
            c_done_q <= 1'b0;
        end else if (cyc_end && !s_go && !c_repeat_q) begin
            c_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // conversion core commands
    // ------------------------------------------------------------------
    logic start_q;
    logic abort_q;
    logic store_q;
    adcc_cmd_t cmd_q;
    logic scan_next;
    logic single_end;

    // a single ending by done or stop hands back to scan
    assign single_end = (state_q == ADCC_SINGLE) && !s_go &&
        (s_halt || conv_done);
    // the scan needs a fresh conversion this cycle
    assign scan_next = !c_halt && !s_go &&
        (((state_q == ADCC_SCAN) &&
          (c_go || (conv_done && (!cyc_end || c_repeat_q)))) ||
         ((state_q == ADCC_IDLE) && c_go) ||
         (single_end && (scan_held_q || scan_queued_q || c_go)));

    // channel of the next scan conversion after a done or a restart
    function automatic logic [3:0] scan_target(input logic restart,
                                               input logic wrap,
                                               input logic [3:0] ch);
        if (restart || wrap) begin
            scan_target = 4'h0;
        end else begin
            scan_target = ch;
        end
    endfunction

    // start, stop and store pulses; mode and rate follow the source
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            store_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            start_q <= s_go || scan_next;
            // stop freezes the partial value, nothing stored
            // a resuming scan start cancels the core itself, no abort
            abort_q <= !scan_next && ((state_q == ADCC_SINGLE && s_halt) ||
                (state_q == ADCC_SCAN && c_halt));
            store_q <= conv_done && ((state_q == ADCC_SINGLE && !s_halt) ||
                (state_q == ADCC_SCAN && !c_halt && !s_go && !c_go));
            if (s_go) begin
                // a new start restarts a running single
                cmd_q <= '{channel: s_ch_q, compare: s_func_q,
                           rate: s_rate_q};
            end else if (scan_next) begin
                cmd_q <= '{channel: state_q == ADCC_SCAN && conv_done &&
                                    !c_go
                                ? scan_target(1'b0, cyc_end,
                                              scan_ch_q + 4'h1)
                                : scan_target(c_go || scan_queued_q,
                                              1'b0, scan_ch_q),
                           compare: 1'b0, rate: 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt or dma request on completion
    // ------------------------------------------------------------------
    adcc_req_t req_q;
    logic s_fin;
    logic c_fin;

    assign s_fin = (state_q == ADCC_SINGLE) && conv_done && !s_halt;
    assign c_fin = cyc_end && !c_halt && !s_go && !c_go;

    // each source routes its own end to one of the two lines
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
        end else begin
            req_q.irq <= (s_fin && !s_req_q) ||
                (c_fin && !c_req_q);
            req_q.dma <= (s_fin && s_req_q) || (c_fin && c_req_q);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // captured during the wait cycle so it stands at the answer edge;
    // go and halt read zero, unmapped words read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && wait_q) begin
            unique case (avs_address)
                `ADCC_SIM0_IDX:
                    rdata_q <= {24'h00_0000, 2'b00, s_hwsrc_q, s_trig_q,
                                s_req_q, s_done_q, 2'b00};
                `ADCC_SIM1_IDX:
                    rdata_q <= {24'h00_0000, s_func_q, s_rate_q, 2'b00,
                                s_ch_q};
                `ADCC_SCM0_IDX:
                    rdata_q <= {24'h00_0000, 1'b0, c_repeat_q, c_hwsrc_q,
                                c_trig_q, c_req_q, c_done_q, 2'b00};
                default:
                    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign conv_cmd = cmd_q;
    assign conv_start = start_q;
    assign conv_abort = abort_q;
    assign conv_store = store_q;
    assign done_req = req_q;

endmodule
`default_nettype wire
